// file: lin_mode_cfg.svh
// Timing counts and field encodings for the dual-channel bus transceiver mode control.
// Assumes a 100 MHz clock; included by its bare name.
`ifndef LIN_MODE_CFG_SVH
`define LIN_MODE_CFG_SVH
// Mode field encodings (two bits per channel)
`define LIN_MODE_OFF 2'h0
`define LIN_MODE_WAKE 2'h1
`define LIN_MODE_NORMAL 2'h2
`define LIN_MODE_RXONLY 2'h3
// System mode encodings (three bits)
`define SYS_MODE_NORMAL 3'h0
`define SYS_MODE_STOP 3'h1
`define SYS_MODE_SLEEP 3'h2
`define SYS_MODE_RESTART 3'h3
`define SYS_MODE_FAILSAFE 3'h4
// Clock period in ns and enabling delay in us
`define CLK_PERIOD_NS 10
`define LIN_EN_TIME_US 20
`define LIN_EN_CYCLES ((`LIN_EN_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: lin_mode_pkg.sv
// Types shared by the transceiver mode control files.
// Assumes lin_mode_cfg.svh supplies the numbers.
package lin_mode_pkg;
  // Per-channel state held by each channel engine
  typedef struct packed {
    logic [1:0] mode;     // Mode in force
    logic [15:0] timer;   // Enabling delay down-counter
    logic armed;          // Enabling delay has elapsed
    logic tx_gate;        // Transmit input accepted onto the bus
    logic woken;          // Wake seen in wake-capable mode
    logic tx_n;           // Registered bus drive, low for dominant
    logic rx;             // Registered receive output
  } chan_state_t;
  // A mode request: strobe plus requested field value
  typedef struct packed {
    logic write;
    logic [1:0] mode;
  } mode_req_t;
endpackage

// file: lin_chan.sv
// One transceiver channel: mode register, enabling delay, drive and receive gating.
// Assumes an active-low reset whose release the top module has already synchronised.
`include "lin_mode_cfg.svh"
module lin_chan #(
  parameter int EN_CYCLES = `LIN_EN_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] sys_mode,
  input wire lin_mode_pkg::mode_req_t req,
  input wire logic bus_tx_input,
  input wire logic bus_level,
  output logic [1:0] mode,
  output logic drive_n,
  output logic rx_out,
  output logic wake
);
  lin_mode_pkg::chan_state_t state_reg, state_next;
  logic permitted; // Normal or Receive Only allowed in this system mode
  logic rx_active; // Receiver running
  logic enter_normal; // This cycle's write switches the channel into Normal

  // Next-state logic for the whole channel
  always_comb begin
    state_next = state_reg;
    enter_normal = 1'b0;
    permitted = (sys_mode == `SYS_MODE_NORMAL) || (sys_mode == `SYS_MODE_STOP);
    // Accepting a new mode
    if (req.write) begin
      if (req.mode == `LIN_MODE_OFF) begin
        state_next.mode = `LIN_MODE_OFF;
      end else if (req.mode == `LIN_MODE_WAKE) begin
        state_next.mode = `LIN_MODE_WAKE;
      end else if (permitted) begin
        state_next.mode = req.mode;
      end
      // Otherwise the old mode stays in force
      if (state_next.mode != state_reg.mode) begin
        state_next.woken = 1'b0; // Toggling the mode rearms wake
        enter_normal = (state_next.mode == `LIN_MODE_NORMAL);
      end
    end
    // Entering Normal reloads the delay; the countdown must not overwrite the reload
    if (enter_normal) begin
      state_next.timer = 16'(EN_CYCLES);
      state_next.armed = 1'b0;
      state_next.tx_gate = 1'b0;
    end else if (!state_reg.armed && state_reg.mode == `LIN_MODE_NORMAL) begin
      if (state_reg.timer > 16'h0001) begin
        state_next.timer = state_reg.timer - 16'h0001;
      end else begin
        state_next.armed = 1'b1;
      end
    end
    // Gate opens only once the input has been seen recessive after the delay;
    // an armed flag left from an earlier Normal session must not open it
    if (!enter_normal && state_reg.armed && bus_tx_input) begin
      state_next.tx_gate = 1'b1;
    end
    // Wake detection only while wake-capable mode stays in force; leaving it clears the flag
    if (state_reg.mode == `LIN_MODE_WAKE && state_next.mode == `LIN_MODE_WAKE && !bus_level) begin
      state_next.woken = 1'b1;
    end
    // Rearm while the system is in Stop, Sleep or Fail-safe mode and the bus is recessive
    if (sys_mode == `SYS_MODE_STOP || sys_mode == `SYS_MODE_SLEEP || sys_mode == `SYS_MODE_FAILSAFE) begin
      if (state_reg.mode == `LIN_MODE_WAKE && bus_level) begin
        state_next.woken = 1'b0;
      end
    end
    // Bus drive: dominant only in Normal mode after the gate opens
    if (state_reg.mode == `LIN_MODE_NORMAL && state_reg.tx_gate) begin
      state_next.tx_n = bus_tx_input;
    end else begin
      state_next.tx_n = 1'b1;
    end
    rx_active = (state_reg.mode == `LIN_MODE_NORMAL) || (state_reg.mode == `LIN_MODE_RXONLY);
    // Receive output follows the bus while receiving, low after a wake
    if (rx_active) begin
      state_next.rx = bus_level;
    end else if (state_reg.mode == `LIN_MODE_WAKE && state_reg.woken) begin
      state_next.rx = 1'b0;
    end else begin
      state_next.rx = 1'b1;
    end
  end

  // State register; reset puts the channel in Off mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{mode: `LIN_MODE_OFF, timer: 16'h0000, armed: 1'b0, tx_gate: 1'b0,
                     woken: 1'b0, tx_n: 1'b1, rx: 1'b1};
    end else begin
      state_reg <= state_next;
    end
  end

  assign mode = state_reg.mode;
  assign drive_n = state_reg.tx_n;
  assign rx_out = state_reg.rx;
  assign wake = state_reg.woken;
endmodule

// file: lin_transceiver_mode_control.sv
// Top of the two-channel transceiver mode control with reset release.
// Assumes mode writes arrive as one-cycle strobes from the serial register block.
// Contract
// - Each channel has its own mode field
// - Power-up mode is Off, all stopped
// - Off selectable in every system mode
// - Off mode ignores bus wake events
// - Normal only in system Normal/Stop
// - Host write in Normal enables channel
// - Normal mode: low input drives dominant
// - Active receiver shows bus on output
// - Dominant held over delay end suppressed
// - Receive Only: driver off, receive on
// - Receive Only needs system Normal/Stop
// - Value 01 is wake, shown after wake
`include "lin_mode_cfg.svh"
module lin_transceiver_mode_control #(
  parameter int EN_CYCLES = `LIN_EN_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] sys_mode,
  input wire logic mode_write,
  input wire logic [1:0] chan_a_mode_field_wr,
  input wire logic [1:0] chan_b_mode_field_wr,
  input wire logic [1:0] bus_tx_input,
  input wire logic [1:0] bus_level,
  output logic [1:0] chan_a_mode_field,
  output logic [1:0] chan_b_mode_field,
  output logic [1:0] bus_drive_n,
  output logic [1:0] rx_out,
  output logic [1:0] wake
);
  logic [1:0] sync_reg; // Reset release pipeline
  logic rst_n; // Released reset
  lin_mode_pkg::mode_req_t req [2]; // Per-channel requests
  logic [1:0] mode_out [2]; // Per-channel modes

  // Release reset through two flip-flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= 2'h0;
    end else begin
      sync_reg <= {sync_reg[0], 1'b1};
    end
  end
  assign rst_n = sync_reg[1];

  assign req[0] = '{write: mode_write, mode: chan_a_mode_field_wr};
  assign req[1] = '{write: mode_write, mode: chan_b_mode_field_wr};

  // Two independent channels
  for (genvar i = 0; i < 2; i++) begin : g_chan
    lin_chan #(.EN_CYCLES(EN_CYCLES)) u_chan (
      .clock(clock),
      .rst_n(rst_n),
      .sys_mode(sys_mode),
      .req(req[i]),
      .bus_tx_input(bus_tx_input[i]),
      .bus_level(bus_level[i]),
      .mode(mode_out[i]),
      .drive_n(bus_drive_n[i]),
      .rx_out(rx_out[i]),
      .wake(wake[i])
    );
  end
  assign chan_a_mode_field = mode_out[0];
  assign chan_b_mode_field = mode_out[1];
endmodule

// file: lin_bus_node.sv
// Far side of both channels: the other bus nodes on each wire.
// Assumes the bench sets node_n; the bus pull-up keeps an idle wire recessive.
module lin_bus_node (
  input wire logic [1:0] drive_n,
  input wire logic [1:0] node_n,
  output logic [1:0] bus_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Wired-AND: any node pulling low makes the wire dominant
  assign bus_level = drive_n & node_n;
endmodule

// file: lin_mode_asserts.sv
// Port checker for the two-channel transceiver mode control.
// Assumes binding into the top module; EN_CYCLES is handed on.
module lin_mode_asserts #(parameter int EN_CYCLES = 8) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [2:0] sys_mode,
  input wire logic mode_write,
  input wire logic [1:0] chan_a_mode_field_wr,
  input wire logic [1:0] chan_b_mode_field_wr,
  input wire logic [1:0] bus_tx_input,
  input wire logic [1:0] bus_level,
  input wire logic [1:0] chan_a_mode_field,
  input wire logic [1:0] chan_b_mode_field,
  input wire logic [1:0] bus_drive_n,
  input wire logic [1:0] rx_out,
  input wire logic [1:0] wake
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic [1:0] ma = chan_a_mode_field;
  wire logic [1:0] mb = chan_b_mode_field;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Steady modes only, so a mode change may lag by a cycle
  property p_off; ma == 2'h0 && $past(ma) == 2'h0 |-> rx_out[0] && bus_drive_n[0]; endproperty
  a_off: assert property (p_off) else $error("off channel active");
  property p_nowk; mb == 2'h0 && $past(mb) == 2'h0 |-> !wake[1]; endproperty
  a_nowk: assert property (p_nowk) else $error("wake while off");
  property p_ro; mb == 2'h3 && $past(mb) == 2'h3 |-> bus_drive_n[1]; endproperty
  a_ro: assert property (p_ro) else $error("receive only drives");
  property p_rx; ma[1] && $past(ma) == ma |-> rx_out[0] == $past(bus_level[0]); endproperty
  a_rx: assert property (p_rx) else $error("receive level wrong");
  property p_ref; mode_write && sys_mode > 3'h1 && chan_a_mode_field_wr[1] |=> ma == $past(ma); endproperty
  a_ref: assert property (p_ref) else $error("forbidden mode taken");
  property p_acc; mode_write && (sys_mode < 3'h2 || !chan_b_mode_field_wr[1]) |=> mb == $past(chan_b_mode_field_wr);
  endproperty
  a_acc: assert property (p_acc) else $error("mode write lost");
  // Count written out: EN_CYCLES is 8 in simulation
  property p_en; $rose(ma == 2'h2) |-> bus_drive_n[0] [*8]; endproperty
  a_en: assert property (p_en) else $error("drive within delay");
  property p_tx; !bus_drive_n[0] |-> $past(ma) == 2'h2 && !$past(bus_tx_input[0]); endproperty
  a_tx: assert property (p_tx) else $error("dominant without cause");
  c_en: cover property ($rose(ma == 2'h2));
  c_ref: cover property (mode_write && sys_mode > 3'h1);
  c_wk: cover property ($rose(wake[1]));
endmodule
bind lin_transceiver_mode_control lin_mode_asserts #(.EN_CYCLES(EN_CYCLES)) chk (.clock, .arst_n, .sys_mode,
  .mode_write, .chan_a_mode_field_wr, .chan_b_mode_field_wr, .bus_tx_input, .bus_level, .chan_a_mode_field,
  .chan_b_mode_field, .bus_drive_n, .rx_out, .wake);

// file: lin_transceiver_mode_control_test.sv
// Self-checking bench: mode table first, then enabling, receive-only and wake cases.
// Assumes lin_bus_node as far side; inputs move 1 ns after each rising edge.
module lin_transceiver_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EN = 8;
  logic clock = 1'b0, arst_n = 1'b0, mode_write = 1'b0;
  logic [2:0] sys_mode = 3'h0;
  logic [1:0] chan_a_mode_field_wr = 2'h0, chan_b_mode_field_wr = 2'h0, bus_tx_input = 2'h3, node_n = 2'h3;
  logic [1:0] bus_level, chan_a_mode_field, chan_b_mode_field, bus_drive_n, rx_out, wake;
  int n_mismatch = 0, num_checks = 0, cyc = 0, i;
  // Rows: system mode, requested a and b, expected a and b
  logic [10:0] rows [6] = '{11'h0BB, 11'h2EB, 11'h311, 11'h1EE, 11'h48C, 11'h000};
  always #5 clock = ~clock;
  lin_bus_node bus (.drive_n(bus_drive_n), .node_n, .bus_level);
  lin_transceiver_mode_control #(.EN_CYCLES(EN)) dut (.clock, .arst_n, .sys_mode, .mode_write, .chan_a_mode_field_wr,
    .chan_b_mode_field_wr, .bus_tx_input, .bus_level, .chan_a_mode_field, .chan_b_mode_field, .bus_drive_n, .rx_out,
    .wake);
  `define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
  // One-cycle write strobe, then a settle edge
  task wr(input logic [2:0] s, input logic [1:0] a, b);
    @(posedge clock) #1 {sys_mode, chan_a_mode_field_wr, chan_b_mode_field_wr, mode_write} = {s, a, b, 1'b1};
    @(posedge clock) #1 mode_write = 1'b0;
    @(posedge clock) #1;
  endtask
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard: the run needs about 65 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      results;
    end
  end
  initial begin
    step(8);
    arst_n = 1'b1;
    step(3);
    `CHK({chan_a_mode_field, chan_b_mode_field, bus_drive_n, rx_out, wake}, 10'h03C)
    for (i = 0; i < 6; i++) begin
      wr(rows[i][10:8], rows[i][7:6], rows[i][5:4]);
      `CHK({chan_a_mode_field, chan_b_mode_field}, rows[i][3:0])
    end
    // Early dominant on a, held past the enabling delay
    bus_tx_input = 2'h2;
    wr(3'h0, 2'h2, 2'h3);
    step(EN + 4);
    `CHK(bus_drive_n[0], 1'b1)
    bus_tx_input = 2'h3;
    step(2);
    bus_tx_input = 2'h2;
    step(2);
    `CHK({bus_drive_n, rx_out}, 4'hA)
    node_n = 2'h1;
    bus_tx_input = 2'h1;
    step(2);
    `CHK({bus_drive_n, rx_out}, 4'hD)
    wr(3'h0, 2'h0, 2'h0);
    step(2);
    `CHK({wake, rx_out}, 4'h3)
    wr(3'h0, 2'h0, 2'h1);
    step(2);
    `CHK({chan_b_mode_field, wake[1], rx_out[1]}, 4'h6)
    // Re-entering Normal must restart the delay even with the input recessive
    bus_tx_input = 2'h3;
    wr(3'h0, 2'h2, 2'h0);
    bus_tx_input = 2'h2;
    step(2);
    `CHK(bus_drive_n[0], 1'b1)
    results;
  end
endmodule
